/* src/acc_defines.svh */
// offsets, field positions, reset values and timing counts of the codec control bank
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACC_OFS_CLOCK_CONFIG 5'h03
`define ACC_OFS_SAMPLE_RATE 5'h04
`define ACC_OFS_POWER_DOWN_1 5'h05
`define ACC_OFS_POWER_COUPLE_2 5'h06
`define ACC_OFS_RAMP_CONTROL 5'h07
`define ACC_OFS_IRQ_CONTROL 5'h08
`define ACC_OFS_IRQ_FLAGS 5'h09
`define ACC_OFS_DAC_MIX_GAIN 5'h0A
`define ACC_OFS_MIC_MIXER_CONTROL 5'h16

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ACC_RST_CLOCK_CONFIG 8'h00
`define ACC_RST_SAMPLE_RATE 8'h00
`define ACC_RST_POWER_DOWN_1 8'hFF
`define ACC_RST_POWER_COUPLE_2 8'h03
`define ACC_RST_RAMP_CONTROL 8'h51
`define ACC_RST_IRQ_CONTROL 8'h3F
`define ACC_RST_DAC_MIX_GAIN 8'h00
`define ACC_RST_MIC_MIXER_CONTROL 8'hC0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ACC_POS_ADC_SRC 0
`define ACC_POS_CLK_SRC 0
`define ACC_POS_DAC_RATE 4
`define ACC_POS_ADC_RATE 0
`define ACC_POS_PD_DAC 7
`define ACC_POS_PD_OUT 6
`define ACC_POS_PD_MIX 5
`define ACC_POS_PD_ADC 4
`define ACC_POS_PD_LIN 3
`define ACC_POS_PD_IND 0
`define ACC_PD1_RSVD_MASK 8'h06
`define ACC_POS_IN_COUPLE 6
`define ACC_POS_MIX_COUPLE 4
`define ACC_POS_MIC_BOOST 3
`define ACC_POS_CM_BUF_PD 2
`define ACC_POS_FULL_PD 1
`define ACC_POS_SLEEP 0
`define ACC_POS_RATIO 5
`define ACC_POS_KFAST 2
`define ACC_POS_THRESH 0
`define ACC_RAMP_RSVD_MASK 8'h80
`define ACC_POS_IRQ_FORM 6
`define ACC_POS_JACK 6
`define ACC_POS_JACK_EVENT 5
`define ACC_POS_SHORT 4
`define ACC_POS_DAC_MIX_LEFT 4
`define ACC_POS_DAC_MIX_RIGHT 0

// ----------------------------------------------------------------
// timing counts in system clock cycles
// ----------------------------------------------------------------
`define ACC_IRQ_PULSE_CYCLES 4'h8
`define ACC_CLR_DELAY_CYCLES 3'h4

`endif

/* src/acc_pkg.sv */
// types shared by the codec control bank
package acc_pkg;

  // ----------------------------------------------------------------
  // interrupt output waveform
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IRQ_LEVEL_HIGH = 2'b00,
    ACC_IRQ_LEVEL_LOW = 2'b01,
    ACC_IRQ_PULSE_HIGH = 2'b10,
    ACC_IRQ_PULSE_LOW = 2'b11
  } acc_irq_form_t;

  // ----------------------------------------------------------------
  // adc input source
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_SRC_MIC1 = 2'b00,
    ACC_SRC_MIC2 = 2'b01,
    ACC_SRC_LINE = 2'b10,
    ACC_SRC_MIXER = 2'b11
  } acc_adc_src_t;

  // ----------------------------------------------------------------
  // interrupt pulse state
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ACC_PULSE_IDLE = 1'b0,
    ACC_PULSE_BUSY = 1'b1
  } acc_pulse_state_t;

endpackage

/* src/acc_irq_shaper.sv */
// interrupt output shaping: levels or fixed-length pulses
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_irq_shaper (
  input wire logic clk, // system clock
  input wire logic rst, // synchronous reset, high
  input wire acc_pkg::acc_irq_form_t form, // selected waveform
  input wire logic pending, // some unmasked flag set
  input wire logic trigger, // new unmasked pending this cycle
  output logic irq // interrupt output
);

  // ----------------------------------------------------------------
  // pulse sequencer
  // ----------------------------------------------------------------
  acc_pkg::acc_pulse_state_t state_reg, state_next;
  logic [3:0] count_reg, count_next;
  logic irq_reg, irq_next;

  // next state and waveform
  always_comb begin
    state_next = state_reg;
    count_next = count_reg;
    case (state_reg)
      acc_pkg::ACC_PULSE_IDLE: begin
        if (trigger && form[1]) begin
          state_next = acc_pkg::ACC_PULSE_BUSY;
          count_next = `ACC_IRQ_PULSE_CYCLES - 4'h1;
        end
      end
      acc_pkg::ACC_PULSE_BUSY: begin
        if (count_reg == 4'h0) begin
          state_next = acc_pkg::ACC_PULSE_IDLE;
        end else begin
          count_next = count_reg - 4'h1;
        end
      end
      default: begin
        state_next = acc_pkg::ACC_PULSE_IDLE;
      end
    endcase
    if (!form[1]) begin
      state_next = acc_pkg::ACC_PULSE_IDLE; // level mode cancels a pulse
    end
    case (form)
      acc_pkg::ACC_IRQ_LEVEL_HIGH: irq_next = pending;
      acc_pkg::ACC_IRQ_LEVEL_LOW: irq_next = ~pending;
      acc_pkg::ACC_IRQ_PULSE_HIGH: irq_next = (state_next == acc_pkg::ACC_PULSE_BUSY);
      acc_pkg::ACC_IRQ_PULSE_LOW: irq_next = (state_next != acc_pkg::ACC_PULSE_BUSY);
      default: irq_next = 1'b0;
    endcase
  end

  // state registers
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= acc_pkg::ACC_PULSE_IDLE;
      count_reg <= 4'h0;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      count_reg <= count_next;
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

endmodule

/* src/acc_regs.sv */
// codec control and status register bank with event flags and interrupt
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_regs (
  input wire logic clk, // system clock, 200 MHz
  input wire logic rst, // synchronous reset, high
  input wire logic [4:0] addr, // register offset
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic jack_present, // headphone plug present
  input wire logic short_detect, // output stage short circuit
  input wire logic ramp_up_done, // ramp up end pulse
  input wire logic ramp_down_done, // ramp down end pulse
  input wire logic mute_up_done, // mute gain up end pulse
  input wire logic mute_down_done, // mute gain down end pulse
  output logic adc_src_mic1, // adc takes mic1 both channels
  output logic adc_src_mic2, // adc takes mic2 both channels
  output logic adc_src_line, // adc takes line input
  output logic adc_src_mixer, // adc takes mixer output
  output logic [3:0] clock_source_field, // clock source select
  output logic [3:0] dac_rate_code, // dac sample rate code
  output logic [3:0] adc_rate_code, // adc sample rate code
  output logic dac_power_down, // dac off
  output logic output_stage_power_down, // output stage off
  output logic mixer_power_down, // mixer off
  output logic adc_power_down, // adc off
  output logic line_input_power_down, // line input off
  output logic mixer_to_adc_power_down, // mixer-to-adc path off
  output logic common_mode_buffer_power_down, // cm buffer off
  output logic complete_power_down, // whole codec off
  output logic low_power_sleep, // sleep mode
  output logic input_gain_couple_left, // both input gains from left
  output logic input_gain_couple_right, // both input gains from right
  output logic dac_mix_couple_left, // both mix gains from left
  output logic dac_mix_couple_right, // both mix gains from right
  output logic [3:0] dac_mix_left_level, // effective left mix gain
  output logic [3:0] dac_mix_right_level, // effective right mix gain
  output logic mic_boost_select, // mic1 boost 20 dB
  output logic [3:0] ramp_ratio, // fast to slow step ratio
  output logic [5:0] fast_slope_factor, // fast slope step factor
  output logic [7:0] slope_threshold, // fast/slow boundary
  output logic irq // interrupt output
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // coupling code to {left from left-or-right, right from ...}: 1 means use right
  function automatic logic [1:0] couple_pick(input logic [1:0] code);
    case (code)
      2'b00: couple_pick = 2'b01; // independent
      2'b01: couple_pick = 2'b00; // both from left
      default: couple_pick = 2'b11; // both from right
    endcase
  endfunction

  function automatic logic [5:0] pow2(input logic [2:0] code);
    pow2 = 6'h01 << code;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] clk_cfg_reg, clk_cfg_next;
  logic [7:0] rate_reg, rate_next;
  logic [7:0] pd1_reg, pd1_next;
  logic [7:0] pd2_reg, pd2_next;
  logic [7:0] ramp_reg, ramp_next;
  logic [7:0] icr_reg, icr_next;
  logic [7:0] mix_reg, mix_next;
  logic [7:0] micmix_reg, micmix_next;
  logic [7:0] rdata_reg, rdata_next;
  logic wr_clock_config, wr_rate, wr_pd1, wr_pd2;
  logic wr_ramp, wr_icr, wr_flags, wr_mix, wr_micmix;

  // write decode
  always_comb begin
    wr_clock_config = wr && (addr == `ACC_OFS_CLOCK_CONFIG);
    wr_rate = wr && (addr == `ACC_OFS_SAMPLE_RATE);
    wr_pd1 = wr && (addr == `ACC_OFS_POWER_DOWN_1);
    wr_pd2 = wr && (addr == `ACC_OFS_POWER_COUPLE_2);
    wr_ramp = wr && (addr == `ACC_OFS_RAMP_CONTROL);
    wr_icr = wr && (addr == `ACC_OFS_IRQ_CONTROL);
    wr_flags = wr && (addr == `ACC_OFS_IRQ_FLAGS);
    wr_mix = wr && (addr == `ACC_OFS_DAC_MIX_GAIN);
    wr_micmix = wr && (addr == `ACC_OFS_MIC_MIXER_CONTROL);
  end

  // reserved power bits 2:1 read one, ramp bit 7 reads zero
  // control register next values
  always_comb begin
    clk_cfg_next = wr_clock_config ? wdata : clk_cfg_reg;
    rate_next = wr_rate ? wdata : rate_reg;
    pd1_next = wr_pd1 ? (wdata | `ACC_PD1_RSVD_MASK) : pd1_reg;
    pd2_next = wr_pd2 ? wdata : pd2_reg;
    ramp_next = wr_ramp ? (wdata & ~`ACC_RAMP_RSVD_MASK) : ramp_reg;
    icr_next = wr_icr ? wdata : icr_reg;
    mix_next = wr_mix ? wdata : mix_reg;
    micmix_next = wr_micmix ? wdata : micmix_reg;
  end

  // control register storage
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_cfg_reg <= `ACC_RST_CLOCK_CONFIG;
      rate_reg <= `ACC_RST_SAMPLE_RATE;
      pd1_reg <= `ACC_RST_POWER_DOWN_1;
      pd2_reg <= `ACC_RST_POWER_COUPLE_2;
      ramp_reg <= `ACC_RST_RAMP_CONTROL;
      icr_reg <= `ACC_RST_IRQ_CONTROL;
      mix_reg <= `ACC_RST_DAC_MIX_GAIN;
      micmix_reg <= `ACC_RST_MIC_MIXER_CONTROL;
    end else begin
      clk_cfg_reg <= clk_cfg_next;
      rate_reg <= rate_next;
      pd1_reg <= pd1_next;
      pd2_reg <= pd2_next;
      ramp_reg <= ramp_next;
      icr_reg <= icr_next;
      mix_reg <= mix_next;
      micmix_reg <= micmix_next;
    end
  end

  // ----------------------------------------------------------------
  // event flags
  // ----------------------------------------------------------------
  logic jack_reg, jack_next;
  logic short_reg, short_next;
  logic jack_evt_reg, jack_evt_next;
  logic [3:0] done_reg, done_next;
  logic [2:0] age_reg [4];
  logic [2:0] age_next [4];
  logic [3:0] done_evt;
  logic [5:0] flags;
  logic [5:0] pend_reg, pend_next;

  assign done_evt = {ramp_up_done, ramp_down_done, mute_up_done, mute_down_done};
  assign flags = {jack_evt_reg, short_reg, done_reg};

  // age counts edges since a done flag set, saturating at the clear delay
  // early clears of a done flag are dropped, not held back for later
  // flag next values, set wins over clear
  always_comb begin
    jack_next = jack_present;
    short_next = short_detect;
    jack_evt_next = jack_evt_reg;
    if (wr_flags && wdata[`ACC_POS_JACK_EVENT]) begin
      jack_evt_next = 1'b0;
    end
    if (jack_present != jack_reg) begin
      jack_evt_next = 1'b1;
    end
    for (int i = 0; i < 4; i++) begin
      done_next[i] = done_reg[i];
      age_next[i] = age_reg[i];
      if (done_reg[i] && age_reg[i] != `ACC_CLR_DELAY_CYCLES) begin
        age_next[i] = age_reg[i] + 3'h1;
      end
      if (wr_flags && wdata[i] && age_reg[i] == `ACC_CLR_DELAY_CYCLES) begin
        done_next[i] = 1'b0;
        age_next[i] = 3'h0;
      end
      if (done_evt[i]) begin
        done_next[i] = 1'b1;
        if (!done_reg[i] || !done_next[i]) begin
          age_next[i] = 3'h0;
        end
      end
    end
    pend_next = flags & ~icr_reg[5:0];
  end

  // flag storage
  always_ff @(posedge clk) begin
    if (rst) begin
      jack_reg <= 1'b0;
      short_reg <= 1'b0;
      jack_evt_reg <= 1'b0;
      done_reg <= 4'h0;
      pend_reg <= 6'h00;
      for (int i = 0; i < 4; i++) begin
        age_reg[i] <= 3'h0;
      end
    end else begin
      jack_reg <= jack_next;
      short_reg <= short_next;
      jack_evt_reg <= jack_evt_next;
      done_reg <= done_next;
      pend_reg <= pend_next;
      for (int i = 0; i < 4; i++) begin
        age_reg[i] <= age_next[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------
  logic [5:0] pend_now;
  logic irq_trigger;

  // pend_reg holds last cycle's unmasked set, so a flag
  // that simply stays set cannot start a second pulse
  // new event or unmask raises a fresh unmasked bit
  always_comb begin
    pend_now = flags & ~icr_reg[5:0];
    irq_trigger = |(pend_now & ~pend_reg);
  end

  acc_irq_shaper u_irq (
    .clk(clk),
    .rst(rst),
    .form(acc_pkg::acc_irq_form_t'(icr_reg[`ACC_POS_IRQ_FORM +: 2])),
    .pending(|pend_now),
    .trigger(irq_trigger),
    .irq(irq)
  );

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // flag read: bit 7 zero, plug and short bits are live status
  // read mux, zero outside the cycle after rd
  always_comb begin
    rdata_next = 8'h00;
    if (rd) begin
      case (addr)
        `ACC_OFS_CLOCK_CONFIG: rdata_next = clk_cfg_reg;
        `ACC_OFS_SAMPLE_RATE: rdata_next = rate_reg;
        `ACC_OFS_POWER_DOWN_1: rdata_next = pd1_reg;
        `ACC_OFS_POWER_COUPLE_2: rdata_next = pd2_reg;
        `ACC_OFS_RAMP_CONTROL: rdata_next = ramp_reg;
        `ACC_OFS_IRQ_CONTROL: rdata_next = icr_reg;
        `ACC_OFS_IRQ_FLAGS: rdata_next = {1'b0, jack_reg, flags};
        `ACC_OFS_DAC_MIX_GAIN: rdata_next = mix_reg;
        `ACC_OFS_MIC_MIXER_CONTROL: rdata_next = micmix_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

  // ----------------------------------------------------------------
  // decoded control outputs
  // ----------------------------------------------------------------
  acc_pkg::acc_adc_src_t adc_src;
  logic [1:0] in_pick, mix_pick;
  logic [3:0] mix_l, mix_r;

  // adc source one-hot
  always_comb begin
    adc_src = acc_pkg::acc_adc_src_t'(micmix_reg[`ACC_POS_ADC_SRC +: 2]);
    adc_src_mic1 = (adc_src == acc_pkg::ACC_SRC_MIC1);
    adc_src_mic2 = (adc_src == acc_pkg::ACC_SRC_MIC2);
    adc_src_line = (adc_src == acc_pkg::ACC_SRC_LINE);
    adc_src_mixer = (adc_src == acc_pkg::ACC_SRC_MIXER);
  end

  // clock, rate and power fields
  always_comb begin
    clock_source_field = clk_cfg_reg[`ACC_POS_CLK_SRC +: 4];
    dac_rate_code = rate_reg[`ACC_POS_DAC_RATE +: 4];
    adc_rate_code = rate_reg[`ACC_POS_ADC_RATE +: 4];
    dac_power_down = pd1_reg[`ACC_POS_PD_DAC];
    output_stage_power_down = pd1_reg[`ACC_POS_PD_OUT];
    mixer_power_down = pd1_reg[`ACC_POS_PD_MIX];
    adc_power_down = pd1_reg[`ACC_POS_PD_ADC];
    line_input_power_down = pd1_reg[`ACC_POS_PD_LIN];
    mixer_to_adc_power_down = pd1_reg[`ACC_POS_PD_IND];
    common_mode_buffer_power_down = pd2_reg[`ACC_POS_CM_BUF_PD];
    complete_power_down = pd2_reg[`ACC_POS_FULL_PD];
    low_power_sleep = pd2_reg[`ACC_POS_SLEEP];
    mic_boost_select = pd2_reg[`ACC_POS_MIC_BOOST];
  end

  // gain coupling
  always_comb begin
    in_pick = couple_pick(pd2_reg[`ACC_POS_IN_COUPLE +: 2]);
    mix_pick = couple_pick(pd2_reg[`ACC_POS_MIX_COUPLE +: 2]);
    input_gain_couple_left = (in_pick == 2'b00);
    input_gain_couple_right = (in_pick == 2'b11);
    dac_mix_couple_left = (mix_pick == 2'b00);
    dac_mix_couple_right = (mix_pick == 2'b11);
    mix_l = mix_reg[`ACC_POS_DAC_MIX_LEFT +: 4];
    mix_r = mix_reg[`ACC_POS_DAC_MIX_RIGHT +: 4];
    dac_mix_left_level = mix_pick[1] ? mix_r : mix_l;
    dac_mix_right_level = mix_pick[0] ? mix_r : mix_l;
  end

  // ramp parameters
  always_comb begin
    ramp_ratio = {2'b00, 2'b00} | 4'(pow2({1'b0, ramp_reg[`ACC_POS_RATIO +: 2]}));
    // undefined fast slope codes saturate at the largest factor
    if (ramp_reg[`ACC_POS_KFAST +: 3] > 3'b101) begin
      fast_slope_factor = pow2(3'b101);
    end else begin
      fast_slope_factor = pow2(ramp_reg[`ACC_POS_KFAST +: 3]);
    end
    case (ramp_reg[`ACC_POS_THRESH +: 2])
      2'b00: slope_threshold = 8'h00;
      2'b01: slope_threshold = 8'h20;
      2'b10: slope_threshold = 8'h40;
      default: slope_threshold = 8'h80;
    endcase
  end

endmodule

/* sim/acc_regs_props.sv */
// port-level assertions for the codec control bank
`timescale 1ns/1ps

module acc_regs_chk (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [4:0] addr, // offset
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic adc_src_mic1, // mic1
  input wire logic adc_src_mic2, // mic2
  input wire logic adc_src_line, // line
  input wire logic adc_src_mixer, // mixer
  input wire logic [3:0] dac_rate_code, // dac rate
  input wire logic [3:0] adc_rate_code, // adc rate
  input wire logic input_gain_couple_left, // in left
  input wire logic input_gain_couple_right, // in right
  input wire logic dac_mix_couple_left, // mix left
  input wire logic dac_mix_couple_right, // mix right
  input wire logic [3:0] dac_mix_left_level, // left level
  input wire logic [3:0] dac_mix_right_level, // right level
  input wire logic mic_boost_select, // boost
  input wire logic [3:0] ramp_ratio, // ratio
  input wire logic [5:0] fast_slope_factor, // fast factor
  input wire logic [7:0] slope_threshold, // threshold
  input wire logic irq // interrupt
);
  logic [7:0] wd_q;
  logic [1:0] form_q;

  // ----------------------------------------------------------------
  // shadows of last write data and waveform
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    wd_q <= wdata;
    if (rst) begin
      form_q <= 2'b00;
    end else if (wr && addr == 5'h08) begin
      form_q <= wdata[7:6];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  chk_src_onehot: assert property (
    $onehot({adc_src_mic1, adc_src_mic2, adc_src_line, adc_src_mixer}))
    else $error("adc source not one-hot");
  chk_src_decode: assert property (
    wr && addr == 5'h16 |=> adc_src_mixer == (wd_q[1:0] == 2'b11)
      && adc_src_line == (wd_q[1:0] == 2'b10) && adc_src_mic2 == (wd_q[1:0] == 2'b01))
    else $error("adc source decode wrong");
  chk_rate_split: assert property (
    wr && addr == 5'h04 |=> dac_rate_code == wd_q[7:4] && adc_rate_code == wd_q[3:0])
    else $error("rate nibbles wrong");
  chk_couple_code: assert property (
    wr && addr == 5'h06 |=> input_gain_couple_left == (wd_q[7:6] == 2'b01)
      && input_gain_couple_right == wd_q[7] && dac_mix_couple_left == (wd_q[5:4] == 2'b01)
      && dac_mix_couple_right == wd_q[5])
    else $error("coupling decode wrong");
  chk_boost_bit: assert property (
    wr && addr == 5'h06 |=> mic_boost_select == wd_q[3])
    else $error("boost bit wrong");
  chk_mix_equal: assert property (
    dac_mix_couple_left || dac_mix_couple_right |-> dac_mix_left_level == dac_mix_right_level)
    else $error("coupled mix levels differ");
  chk_ramp_decode: assert property (
    wr && addr == 5'h07 |=> ramp_ratio == (4'h1 << wd_q[6:5])
      && fast_slope_factor == (wd_q[4:2] > 3'h5 ? 6'h20 : 6'h01 << wd_q[4:2])
      && slope_threshold == (wd_q[1:0] == 2'b00 ? 8'h00 : 8'h10 << wd_q[1:0]))
    else $error("ramp decode wrong");
  chk_pulse_high: assert property (
    form_q == 2'b10 && $rose(irq) |-> irq [*8] ##1 !irq)
    else $error("high pulse length wrong");
  chk_pulse_low: assert property (
    form_q == 2'b11 && $fell(irq) |-> !irq [*8] ##1 irq)
    else $error("low pulse length wrong");
endmodule

bind acc_regs acc_regs_chk chk_u (.*);

/* sim/tb_acc_regs.sv */
// self-checking bench for the codec control bank
`timescale 1ns/1ps

module tb_acc_regs;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic jack_present = 1'b0;
  logic short_detect = 1'b0;
  logic [3:0] done = 4'h0;
  logic ramp_up_done, ramp_down_done, mute_up_done, mute_down_done;
  logic [7:0] rdata, slope_threshold, pd, v, d;
  logic [5:0] fast_slope_factor;
  logic [3:0] clock_source_field, dac_rate_code, adc_rate_code, ramp_ratio;
  logic [3:0] dac_mix_left_level, dac_mix_right_level;
  logic adc_src_mic1, adc_src_mic2, adc_src_line, adc_src_mixer, irq;
  logic dac_power_down, output_stage_power_down, mixer_power_down, adc_power_down;
  logic line_input_power_down, mixer_to_adc_power_down, common_mode_buffer_power_down;
  logic complete_power_down, low_power_sleep, mic_boost_select;
  logic input_gain_couple_left, input_gain_couple_right;
  logic dac_mix_couple_left, dac_mix_couple_right;
  logic [4:0] a;
  int k;
  int errors = 0;
  int compares = 0;
  logic [4:0] ofs [9] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h09, 5'h08, 5'h0A, 5'h16};
  logic [7:0] rstv [9] = '{8'h00, 8'h00, 8'hFF, 8'h03, 8'h51, 8'h00, 8'h3F, 8'h00, 8'hC0};

  assign {ramp_up_done, ramp_down_done, mute_up_done, mute_down_done} = done;
  assign pd = {dac_power_down, output_stage_power_down, mixer_power_down, adc_power_down,
    line_input_power_down, 2'b00, mixer_to_adc_power_down};

  acc_regs dut_u (.*);

  // clock generator
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [7:0] e, input logic [7:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wreg(input logic [4:0] ad, input logic [7:0] dt);
    @(posedge clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= dt;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [4:0] ad, output logic [7:0] dt);
    @(posedge clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge clk);
    rd <= 1'b0;
    #1 dt = rdata;
  endtask

  task automatic rchk(input logic [4:0] ad, input logic [7:0] e);
    logic [7:0] s;
    rreg(ad, s);
    check($sformatf("reg_%h", ad), e, s);
  endtask

  task automatic ev(input int i);
    @(posedge clk);
    done[i] <= 1'b1;
    @(posedge clk);
    done[i] <= 1'b0;
  endtask

  task automatic irqchk(input logic e);
    repeat (3) @(posedge clk);
    #1 check("irq", {7'h00, e}, {7'h00, irq});
  endtask

  task automatic close_out();
    if (errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h6C0B));
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rchk(ofs[i], rstv[i]);
    rchk(5'h1F, 8'h00);
    check("pd", 8'hF9, pd);
    check("pd2", 8'h03, {5'h00, common_mode_buffer_power_down, complete_power_down,
      low_power_sleep});
    check("clk_src", 8'h00, {4'h0, clock_source_field});
    // random write and read back of plain registers
    for (int i = 0; i < 40; i++) begin
      k = $urandom_range(6);
      a = ofs[k < 5 ? k : k + 2];
      d = 8'($urandom);
      if (a == 5'h03) d[3:0] = 4'h0;
      wreg(a, d);
      rchk(a, a == 5'h05 ? d | 8'h06 : a == 5'h07 ? d & 8'h7F : d);
      if (a == 5'h06) check("pd2", {5'h00, d[2:0]}, {5'h00, common_mode_buffer_power_down,
        complete_power_down, low_power_sleep});
      if (a == 5'h03) check("clk_src", {4'h0, d[3:0]}, {4'h0, clock_source_field});
    end
    wreg(5'h07, 8'h51);
    wreg(5'h16, 8'hC0);
    wreg(5'h05, 8'h00);
    #1 check("pd", 8'h00, pd);
    // coupling of the mix gains over all four codes
    wreg(5'h0A, 8'h5A);
    for (int c = 0; c < 4; c++) begin
      wreg(5'h06, {c[1:0], c[1:0], 4'h0});
      #1 check("mix", c == 0 ? 8'h5A : c == 1 ? 8'h55 : 8'hAA,
        {dac_mix_left_level, dac_mix_right_level});
    end
    // done flags: early clear lost, late clear taken
    for (int i = 0; i < 4; i++) begin
      ev(i);
      wreg(5'h09, 8'h01 << i);
      rchk(5'h09, 8'h01 << i);
      wreg(5'h09, 8'h01 << i);
      rchk(5'h09, 8'h00);
    end
    // interrupt waveforms, masking and write-back clear
    wreg(5'h08, 8'h80);
    ev(3);
    irqchk(1'b1);
    repeat (8) @(posedge clk);
    irqchk(1'b0);
    wreg(5'h09, 8'h08);
    wreg(5'h08, 8'hFF);
    ev(0);
    irqchk(1'b1);
    rchk(5'h09, 8'h01);
    wreg(5'h08, 8'hC0);
    irqchk(1'b0);
    repeat (10) @(posedge clk);
    irqchk(1'b1);
    wreg(5'h08, 8'h00);
    irqchk(1'b1);
    wreg(5'h08, 8'h40);
    irqchk(1'b0);
    rreg(5'h09, v);
    wreg(5'h09, v);
    irqchk(1'b1);
    rchk(5'h09, 8'h00);
    wreg(5'h08, 8'h3F);
    // plug status, change flag and short status
    jack_present <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(5'h09, 8'h60);
    wreg(5'h09, 8'h40);
    rchk(5'h09, 8'h60);
    wreg(5'h09, 8'h20);
    rchk(5'h09, 8'h40);
    @(posedge clk);
    short_detect <= 1'b1;
    repeat (3) @(posedge clk);
    wreg(5'h09, 8'h10);
    rchk(5'h09, 8'h50);
    @(posedge clk);
    jack_present <= 1'b0;
    repeat (3) @(posedge clk);
    rchk(5'h09, 8'h30);
    close_out();
  end

  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    close_out();
  end
endmodule
